// ===== hw/scd_params.svh
// constants of the synchronous clock divider
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// number of divider stages: divide by two, four and eight
`define SCD_STAGES 3
// reset value of the divider count, all true outputs low
`define SCD_CNT_RST 3'h0
// reset value of a single stage
`define SCD_BIT_RST 1'b0
// reset value of the falling-edge freeze flag
`define SCD_HOLD_RST 1'b0

`endif

// ===== hw/scd_pkg.sv
// types of the synchronous clock divider
package scd_pkg;

   // recovery from master reset, one-hot
   typedef enum logic [1:0] {
      SCD_RCV_RESET = 2'h1,
      SCD_RCV_RUN = 2'h2
   } scd_rcv_e;

endpackage

// ===== hw/scd_stage_if.sv
// carrier between the divider control and one toggle stage
`timescale 1ns/1ns
`default_nettype none

interface scd_stage_if;
   logic advance;
   logic carry_in;
   logic q;
   logic q_n;

   modport stage
   (
      input advance,
      input carry_in,
      output q,
      output q_n
   );

   modport ctrl
   (
      output advance,
      output carry_in,
      input q,
      input q_n
   );
endinterface

`default_nettype wire

// ===== hw/scd_stage.sv
// one synchronous toggle stage with true and complement outputs
`timescale 1ns/1ns
`default_nettype none
`include "scd_params.svh"

module scd_stage
(
   input wire logic clk,
   input wire logic rst,
   scd_stage_if.stage sif
);

   logic q_reg;
   logic q_next;

   // toggle when the chain advances and all lower stages are high
   always_comb
   begin
      q_next = q_reg ^ (sif.advance & sif.carry_in);
   end

   // true level, cleared by master reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q_reg <= `SCD_BIT_RST;
      end
      else
      begin
         q_reg <= q_next;
      end
   end

   // complement from its own flop, high during reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sif.q_n <= ~`SCD_BIT_RST;
      end
      else
      begin
         sif.q_n <= ~q_next;
      end
   end

   assign sif.q = q_reg;

endmodule

`default_nettype wire

// ===== hw/scd_divider.sv
// synchronous divide by two, four and eight with freeze and master reset
// Function
// - reset released clock high: step on second rise
// - reset released clock low: step on third rise
// - enable high freezes at next falling edge
// - frozen stages hold, outputs keep levels
// - enable low unfreezes at falling edge, phase kept
// - three synchronous outputs: half, quarter, eighth rate
// - master reset clears all stages, clock independent
// - stages start random; pulse reset before use
// - low enable and reset mean run
`timescale 1ns/1ns
`default_nettype none
`include "scd_params.svh"

module scd_divider
#(
   parameter int STAGES = `SCD_STAGES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic enable_n,
   output logic half_rate_out,
   output logic half_rate_out_n,
   output logic quarter_rate_out,
   output logic quarter_rate_out_n,
   output logic eighth_rate_out,
   output logic eighth_rate_out_n
);

   // ****************************************************************
   // reset recovery and freeze control
   // ****************************************************************

   logic release_seen_reg;
   logic hold_reg;
   scd_pkg::scd_rcv_e rcv_reg;
   scd_pkg::scd_rcv_e rcv_next;
   logic advance;
   logic [STAGES-1:0] count_w;
   logic [STAGES-1:0] count_n_w;

   // falling edge marks the reset release as seen
   always_ff @(negedge clk or posedge rst)
   begin
      if (rst)
      begin
         release_seen_reg <= 1'b0;
      end
      else
      begin
         release_seen_reg <= 1'b1;
      end
   end

   // freeze flag taken only on falling edges, so no runt advance
   always_ff @(negedge clk or posedge rst)
   begin
      if (rst)
      begin
         hold_reg <= `SCD_HOLD_RST;
      end
      else
      begin
         hold_reg <= enable_n;
      end
   end

   // rising edge after the seen release arms the chain
   always_comb
   begin
      rcv_next = rcv_reg;
      unique case (rcv_reg)
         scd_pkg::SCD_RCV_RESET:
         begin
            if (release_seen_reg)
            begin
               rcv_next = scd_pkg::SCD_RCV_RUN;
            end
         end
         scd_pkg::SCD_RCV_RUN:
         begin
            rcv_next = scd_pkg::SCD_RCV_RUN;
         end
         default:
         begin
            rcv_next = scd_pkg::SCD_RCV_RESET;
         end
      endcase
   end

   // recovery state register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rcv_reg <= scd_pkg::SCD_RCV_RESET;
      end
      else
      begin
         rcv_reg <= rcv_next;
      end
   end

   // a low enable with reset gone lets the chain count
   assign advance = (rcv_reg == scd_pkg::SCD_RCV_RUN) && !hold_reg;

   // ****************************************************************
   // divider stages
   // ****************************************************************

   genvar gi;
   generate
      for (gi = 0; gi < STAGES; gi++)
      begin : g_stage
         scd_stage_if sif ();
         assign sif.advance = advance;
         // ripple carry of a synchronous counter keeps common edges aligned
         if (gi == 0)
         begin : g_lsb
            assign sif.carry_in = 1'b1;
         end
         else
         begin : g_upper
            assign sif.carry_in = &count_w[gi-1:0];
         end
         assign count_w[gi] = sif.q;
         assign count_n_w[gi] = sif.q_n;
         scd_stage u_stage
         (
            .clk(clk),
            .rst(rst),
            .sif(sif)
         );
      end
   endgenerate

   // outputs straight from the stage flops
   assign half_rate_out = count_w[0];
   assign half_rate_out_n = count_n_w[0];
   assign quarter_rate_out = count_w[1];
   assign quarter_rate_out_n = count_n_w[1];
   assign eighth_rate_out = count_w[STAGES-1];
   assign eighth_rate_out_n = count_n_w[STAGES-1];

   // ****************************************************************
   // checks
   // ****************************************************************

   sequence s_release;
      (rcv_reg == scd_pkg::SCD_RCV_RESET) ##1 (rcv_reg == scd_pkg::SCD_RCV_RUN);
   endsequence

   sequence s_first_step;
      (count_w == `SCD_CNT_RST) ##1 (count_w == ($past(hold_reg) ? `SCD_CNT_RST : 3'h1));
   endsequence

   property p_release_step;
      @(posedge clk) disable iff (rst)
      s_release |-> s_first_step;
   endproperty

   a_first_step_after: assert property (p_release_step)
      else $error("first step after reset release wrong");

   a_reset_state_clear: assert property (
      @(posedge clk) disable iff (rst)
      (rcv_reg == scd_pkg::SCD_RCV_RESET) |-> (count_w == `SCD_CNT_RST) && (&count_n_w))
      else $error("outputs not cleared while recovering from reset");

   a_arm_needs_release: assert property (
      @(posedge clk) disable iff (rst)
      $changed(rcv_reg) |-> $past(release_seen_reg))
      else $error("chain armed before release seen");

   a_count_step: assert property (
      @(posedge clk) disable iff (rst)
      advance |=> (count_w == 3'($past(count_w) + 3'h1)))
      else $error("divider did not step");

   a_freeze_hold: assert property (
      @(posedge clk) disable iff (rst)
      (hold_reg && rcv_reg == scd_pkg::SCD_RCV_RUN) [*2] |-> $stable(count_w))
      else $error("divider moved while frozen");

   a_comp_pair: assert property (
      @(posedge clk) disable iff (rst)
      count_n_w == ~count_w)
      else $error("complement output mismatch");

   a_quarter_edge: assert property (
      @(posedge clk) disable iff (rst)
      $rose(quarter_rate_out) |-> $fell(half_rate_out))
      else $error("quarter rate edge not aligned");

   a_eighth_edge: assert property (
      @(posedge clk) disable iff (rst)
      $rose(eighth_rate_out) |-> $fell(quarter_rate_out) && $fell(half_rate_out))
      else $error("eighth rate edge not aligned");

   // falling-edge flag follows the enable level one falling edge later
   a_freeze_take: assert property (
      @(negedge clk) disable iff (rst)
      enable_n |=> hold_reg)
      else $error("freeze request not taken at falling edge");

   a_thaw_take: assert property (
      @(negedge clk) disable iff (rst)
      !enable_n |=> !hold_reg)
      else $error("thaw request not taken at falling edge");

   a_freeze_stall: assert property (
      @(posedge clk) disable iff (rst)
      hold_reg |=> $stable(count_w))
      else $error("divider stepped on a frozen edge");

   a_reset_clears: assert property (
      @(posedge clk)
      rst |-> (count_w == `SCD_CNT_RST) && (&count_n_w))
      else $error("outputs not cleared during master reset");

endmodule

`default_nettype wire

// ===== test/scd_load_model.sv
// downstream clocked load that captures the divided outputs
`timescale 1ns/1ns
`default_nettype none

module scd_load_model
(
   input wire logic clk,
   input wire logic [5:0] taps,
   output logic [5:0] load_q
);
   // a fanout flop takes the outputs on each rising input edge
   always @(posedge clk)
   begin
      load_q <= taps;
   end
endmodule

`default_nettype wire

// ===== test/tb.sv
// self-checking bench of the clock divider with a reference count model
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic clk;
   logic rst;
   logic enable_n;
   logic h, hn, q, qn, e, en;
   logic [2:0] cnt;
   logic seen;
   logic armed;
   logic frz;
   int n_mismatch = 0;
   int tests_run = 0;
   int seed = 32'h993355AF;
   logic [5:0] load_q;
   logic [5:0] last_pins = 6'h15; // reset pattern, complements high

   scd_divider dut
   (
      .clk(clk),
      .rst(rst),
      .enable_n(enable_n),
      .half_rate_out(h),
      .half_rate_out_n(hn),
      .quarter_rate_out(q),
      .quarter_rate_out_n(qn),
      .eighth_rate_out(e),
      .eighth_rate_out_n(en)
   );

   scd_load_model load
   (
      .clk(clk),
      .taps({e, en, q, qn, h, hn}),
      .load_q(load_q)
   );

   // falling edge: release seen, freeze request sampled
   always @(negedge clk or posedge rst)
      if (rst)
      begin
         seen <= 1'b0;
         frz <= 1'b0;
      end
      else
      begin
         seen <= 1'b1;
         frz <= enable_n;
      end

   // rising edge: one arming edge, then count unless frozen
   always @(posedge clk or posedge rst)
      if (rst)
      begin
         armed <= 1'b0;
         cnt <= 3'h0;
      end
      else if (seen && !armed)
         armed <= 1'b1;
      else if (armed && !frz)
         cnt <= cnt + 3'h1;

   // expected pins from the count, complements inverted
   function automatic logic [5:0] outs(input logic [2:0] c);
      return {c[2], ~c[2], c[1], ~c[1], c[0], ~c[0]};
   endfunction

   task automatic check(input string what);
      tests_run++;
      if ({e, en, q, qn, h, hn} !== outs(cnt))
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, outs(cnt), {e, en, q, qn, h, hn});
      end
      // the load flop holds what the pins showed before the last rising edge
      if (load_q !== last_pins)
      begin
         n_mismatch++;
         $display("unexpected %s load: expected %h seen %h", what, last_pins, load_q);
      end
      last_pins = outs(cnt);
   endtask

   // compare each cycle, then draw freeze requests; odds 1 means always
   task automatic run(input int n, input int odds, input string what);
      repeat (n)
      begin
         @(negedge clk);
         check(what);
         enable_n <= (odds != 0) && (({$random(seed)} % odds) == 0);
      end
   endtask

   task automatic print_verdict;
      if (n_mismatch == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // clock generator
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // main sequence
   initial
   begin
      rst = 1'b1;
      enable_n = 1'b0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst <= 1'b0;
      run(40, 0, "release clock low");
      @(posedge clk);
      #2 rst = 1'b1;
      #1 check("in reset");
      @(posedge clk);
      #2 rst = 1'b0;
      run(40, 0, "release clock high");
      run(300, 3, "random freeze");
      run(20, 1, "long freeze");
      run(30, 0, "thaw");
      print_verdict;
   end

   // watchdog
   initial
   begin
      #20000;
      n_mismatch++;
      print_verdict;
   end
endmodule

`default_nettype wire
